// *** legacy_mixer_register_bank_tb.sv ***
`timescale 1ns/1ps
// drives the bank through the host model, checks readback in order
module legacy_mixer_register_bank_tb;
    reg clk = 1'h0;
    reg rst_n = 1'h0;
    reg rdPend = 1'h0;
    wire ioWrStrobe, ioRdStrobe, stereoSel;
    wire [3:0] ioAddr, voiceLeft, voiceRight, masterLeft, masterRight;
    wire [7:0] ioWrData, ioRdData;
    wire [2:0] micLevel;
    wire [1:0] recordSource;
    wire [3:0] synthLeft, synthRight, cdLeft, cdRight, lineLeft, lineRight;
    integer failures = 0, checks_done = 0, i;
    reg [7:0] expQ[$];
    reg [7:0] idxT[0:7], dflt[0:7], cur[0:7], rsv[0:6];
    reg [31:0] seed = 32'h43;
    always #2 clk = ~clk;
    lmrb_host_model host (.clk(clk), .ioWrStrobe(ioWrStrobe), .ioRdStrobe(ioRdStrobe),
        .ioAddr(ioAddr), .ioWrData(ioWrData));
    lmrb_mixer_regs dut (.clk(clk), .rst_n(rst_n), .ioWrStrobe(ioWrStrobe),
        .ioRdStrobe(ioRdStrobe), .ioAddr(ioAddr), .ioWrData(ioWrData), .ioRdData(ioRdData),
        .voiceLeft(voiceLeft), .voiceRight(voiceRight), .micLevel(micLevel),
        .recordSource(recordSource), .stereo_output_select(stereoSel),
        .masterLeft(masterLeft), .masterRight(masterRight), .synthLeft(synthLeft),
        .synthRight(synthRight), .cdLeft(cdLeft), .cdRight(cdRight), .lineLeft(lineLeft),
        .lineRight(lineRight));
    ////////////////////////////////////////////////////////////////
    function [31:0] xs(input [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        xs = s ^ (s << 5);
    endfunction
    task chk(input string nm, input [7:0] seen, input [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // index always goes first, then the data access
    task setr(input [7:0] idx, input [7:0] d);
        host.wr(4'h4, idx);
        host.wr(4'h5, d);
    endtask
    task getr(input [7:0] idx, input [7:0] e);
        host.wr(4'h4, idx);
        expQ.push_back(e);
        host.rd();
    endtask
    task allr;
        integer k;
        for (k = 0; k < 8; k++)
            getr(idxT[k], cur[k]);
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // a read answer lands one edge after its strobe
    always @(posedge clk) begin
        if (rdPend)
            chk("rdata", ioRdData, expQ.pop_front());
        rdPend <= ioRdStrobe && ioAddr == 4'h5;
    end
    // watchdog, generous next to the few hundred cycles needed
    initial begin
        #40000;
        failures++;
        tally_and_finish;
    end
    initial begin
        idxT = '{8'h04, 8'h0A, 8'h0C, 8'h0E, 8'h22, 8'h26, 8'h28, 8'h2E};
        dflt = '{8'h99, 8'h01, 8'h00, 8'h00, 8'h99, 8'h99, 8'h01, 8'h01};
        rsv = '{8'h02, 8'h06, 8'h08, 8'h20, 8'h24, 8'h2A, 8'h2C};
        cur = dflt;
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        allr;
        // random byte into every register, read back whole
        for (i = 0; i < 8; i++) begin
            seed = xs(seed);
            cur[i] = seed[7:0];
            setr(idxT[i], cur[i]);
        end
        allr;
        @(negedge clk);
        chk("voice", {voiceLeft, voiceRight}, cur[0]);
        chk("mic", micLevel, cur[1][2:0]);
        chk("master", {masterLeft, masterRight}, cur[4]);
        chk("synth", {synthLeft, synthRight}, cur[5]);
        chk("cd", {cdLeft, cdRight}, cur[6]);
        chk("line", {lineLeft, lineRight}, cur[7]);
        // every source code and both output formats
        for (i = 0; i < 4; i++) begin
            setr(8'h0C, {i[6:0], 1'h0});
            setr(8'h0E, {i[6:0], 1'h0});
            @(negedge clk);
            chk("source", recordSource, i[1:0]);
            chk("stereo", stereoSel, i[0]);
        end
        cur[2] = 8'h06;
        cur[3] = 8'h06;
        // reserved places swallow writes and read as zero
        for (i = 0; i < 7; i++) begin
            setr(rsv[i], 8'hFF);
            getr(rsv[i], 8'h00);
        end
        allr;
        setr(8'h00, seed[15:8]);
        cur = dflt;
        // every field output back at its default straight after the trigger
        @(negedge clk);
        chk("voice_dflt", {voiceLeft, voiceRight}, dflt[0]);
        chk("mic_dflt", micLevel, dflt[1][2:0]);
        chk("source_dflt", recordSource, dflt[2][2:1]);
        chk("stereo_dflt", stereoSel, dflt[3][1]);
        chk("master_dflt", {masterLeft, masterRight}, dflt[4]);
        chk("synth_dflt", {synthLeft, synthRight}, dflt[5]);
        chk("cd_dflt", {cdLeft, cdRight}, dflt[6]);
        chk("line_dflt", {lineLeft, lineRight}, dflt[7]);
        allr;
        getr(8'h00, 8'h00);
        repeat (4) @(posedge clk);
        tally_and_finish;
    end
endmodule

// *** lmrb_consts.vh ***
`ifndef LMRB_CONSTS_VH
`define LMRB_CONSTS_VH

// port offsets from the legacy io base
`define LMRB_PORT_W 4
`define LMRB_PORT_INDEX 4'h4
`define LMRB_PORT_DATA 4'h5

// mixer indices
`define LMRB_IDX_RESET 8'h00
`define LMRB_IDX_VOICE 8'h04
`define LMRB_IDX_MIC 8'h0A
`define LMRB_IDX_SOURCE 8'h0C
`define LMRB_IDX_FORMAT 8'h0E
`define LMRB_IDX_MASTER 8'h22
`define LMRB_IDX_SYNTH 8'h26
`define LMRB_IDX_CD 8'h28
`define LMRB_IDX_LINE 8'h2E

// reset values
`define LMRB_RST_VOICE 8'h99
`define LMRB_RST_MIC 8'h01
`define LMRB_RST_SOURCE 8'h00
`define LMRB_RST_FORMAT 8'h00
`define LMRB_RST_MASTER 8'h99
`define LMRB_RST_SYNTH 8'h99
`define LMRB_RST_CD 8'h01
`define LMRB_RST_LINE 8'h01
`define LMRB_RST_INDEX 8'h00

// field positions
`define LMRB_LEFT_HI 7
`define LMRB_LEFT_LO 4
`define LMRB_RIGHT_HI 3
`define LMRB_RIGHT_LO 0
`define LMRB_MIC_HI 2
`define LMRB_MIC_LO 0
`define LMRB_SRC_HI 2
`define LMRB_SRC_LO 1
`define LMRB_STEREO_BIT 1

// recording source codes
`define LMRB_SRC_MIC_A 2'h0
`define LMRB_SRC_CD 2'h1
`define LMRB_SRC_MIC_B 2'h2
`define LMRB_SRC_LINE 2'h3

// read value of reserved and write-only indices
`define LMRB_RD_NONE 8'h00

`endif

// *** lmrb_host_model.sv ***
`timescale 1ns/1ps
// host software on the legacy io ports
module lmrb_host_model (
    input wire clk,
    output reg ioWrStrobe = 1'h0,
    output reg ioRdStrobe = 1'h0,
    output reg [3:0] ioAddr = 4'h0,
    output reg [7:0] ioWrData = 8'h00
);
    // one write; released data flips so a stale byte cannot pass
    task wr(input [3:0] a, input [7:0] d);
        @(posedge clk);
        ioWrStrobe <= 1'h1;
        ioAddr <= a;
        ioWrData <= d;
        @(posedge clk);
        ioWrStrobe <= 1'h0;
        ioWrData <= ~d;
    endtask
    // one data port read
    task rd;
        @(posedge clk);
        ioRdStrobe <= 1'h1;
        ioAddr <= 4'h5;
        @(posedge clk);
        ioRdStrobe <= 1'h0;
        ioAddr <= 4'hF;
    endtask
endmodule

// *** lmrb_mixer_regs.v ***
// Overview of operation
// - any write to index 00H returns all mixer registers to defaults
// - index 04H voice level, left high nibble, right low nibble, reset 99H
// - index 0AH microphone level in low field, upper bits stored and read back but unused, reset 01H
// - index 0CH bits 2:1 pick recording source: mic, cd, mic, line
// - index 0EH bit 1 selects mono (0) or stereo (1) output
// - index 22H master level, left high nibble, right low nibble, reset 99H
// - index 26H synth level, left high nibble, right low nibble, reset 99H
// - index 28H cd level, left high nibble, right low nibble, reset 01H
// - index 2EH line level, left high nibble, right low nibble, reset 01H
// - data port reads and writes the register chosen by the stored index
`timescale 1ns/1ps
`include "lmrb_consts.vh"

module lmrb_mixer_regs #(
    parameter DATA_W = 8
) (
    input wire clk,
    input wire rst_n,
    input wire ioWrStrobe,
    input wire ioRdStrobe,
    input wire [`LMRB_PORT_W-1:0] ioAddr,
    input wire [DATA_W-1:0] ioWrData,
    output reg [DATA_W-1:0] ioRdData,
    output wire [3:0] voiceLeft,
    output wire [3:0] voiceRight,
    output wire [2:0] micLevel,
    output wire [1:0] recordSource,
    output wire stereo_output_select,
    output wire [3:0] masterLeft,
    output wire [3:0] masterRight,
    output wire [3:0] synthLeft,
    output wire [3:0] synthRight,
    output wire [3:0] cdLeft,
    output wire [3:0] cdRight,
    output wire [3:0] lineLeft,
    output wire [3:0] lineRight
);

    ////////////////////////////////////////////////////////////////////
    // decode

    reg [DATA_W-1:0] index_reg;
    reg [DATA_W-1:0] voice_reg;
    reg [DATA_W-1:0] mic_reg;
    reg [DATA_W-1:0] source_reg;
    reg [DATA_W-1:0] format_reg;
    reg [DATA_W-1:0] master_reg;
    reg [DATA_W-1:0] synth_reg;
    reg [DATA_W-1:0] cd_reg;
    reg [DATA_W-1:0] line_reg;

    wire indexWr = ioWrStrobe && (ioAddr == `LMRB_PORT_INDEX);
    wire dataWr = ioWrStrobe && (ioAddr == `LMRB_PORT_DATA);
    wire dataRd = ioRdStrobe && (ioAddr == `LMRB_PORT_DATA);

    // one decode used by both the write and the read paths
    function hit;
        input [DATA_W-1:0] idx;
        input [DATA_W-1:0] target;
        begin
            hit = (idx == target);
        end
    endfunction

    wire softReset = dataWr && hit(index_reg, `LMRB_IDX_RESET);

    ////////////////////////////////////////////////////////////////////
    // index register; written only through the index port

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            index_reg <= `LMRB_RST_INDEX;
        end else if (indexWr) begin
            index_reg <= ioWrData;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // mixer registers; soft reset leaves the index alone so software
    // can keep using the same selection afterwards

    // one write enable per stored register, all from the shared decode
    wire voiceWr = dataWr && hit(index_reg, `LMRB_IDX_VOICE);
    wire micWr = dataWr && hit(index_reg, `LMRB_IDX_MIC);
    wire sourceWr = dataWr && hit(index_reg, `LMRB_IDX_SOURCE);
    wire formatWr = dataWr && hit(index_reg, `LMRB_IDX_FORMAT);
    wire masterWr = dataWr && hit(index_reg, `LMRB_IDX_MASTER);
    wire synthWr = dataWr && hit(index_reg, `LMRB_IDX_SYNTH);
    wire cdWr = dataWr && hit(index_reg, `LMRB_IDX_CD);
    wire lineWr = dataWr && hit(index_reg, `LMRB_IDX_LINE);
    // reserved indices raise no enable, so their writes are dropped

    // voice level, left nibble high and right nibble low
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            voice_reg <= `LMRB_RST_VOICE;
        end else if (softReset) begin
            voice_reg <= `LMRB_RST_VOICE;
        end else if (voiceWr) begin
            voice_reg <= ioWrData;
        end
    end

    // mic level; all eight bits kept so readback returns the whole byte
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mic_reg <= `LMRB_RST_MIC;
        end else if (softReset) begin
            mic_reg <= `LMRB_RST_MIC;
        end else if (micWr) begin
            mic_reg <= ioWrData;
        end
    end

    // recording source; only bits 2:1 reach the converter mux
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            source_reg <= `LMRB_RST_SOURCE;
        end else if (softReset) begin
            source_reg <= `LMRB_RST_SOURCE;
        end else if (sourceWr) begin
            source_reg <= ioWrData;
        end
    end

    // output format; bit 1 picks stereo, the rest is stored but unused
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            format_reg <= `LMRB_RST_FORMAT;
        end else if (softReset) begin
            format_reg <= `LMRB_RST_FORMAT;
        end else if (formatWr) begin
            format_reg <= ioWrData;
        end
    end

    // master level, both channels in one byte
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            master_reg <= `LMRB_RST_MASTER;
        end else if (softReset) begin
            master_reg <= `LMRB_RST_MASTER;
        end else if (masterWr) begin
            master_reg <= ioWrData;
        end
    end

    // synthesizer level, both channels in one byte
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            synth_reg <= `LMRB_RST_SYNTH;
        end else if (softReset) begin
            synth_reg <= `LMRB_RST_SYNTH;
        end else if (synthWr) begin
            synth_reg <= ioWrData;
        end
    end

    // cd input level; defaults low so an idle drive stays quiet
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cd_reg <= `LMRB_RST_CD;
        end else if (softReset) begin
            cd_reg <= `LMRB_RST_CD;
        end else if (cdWr) begin
            cd_reg <= ioWrData;
        end
    end

    // line input level; defaults low like the cd input
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            line_reg <= `LMRB_RST_LINE;
        end else if (softReset) begin
            line_reg <= `LMRB_RST_LINE;
        end else if (lineWr) begin
            line_reg <= ioWrData;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read path; registered so data settles a cycle after the strobe

    reg [DATA_W-1:0] rdMux;

    always @* begin
        rdMux = `LMRB_RD_NONE;
        case (1'b1)
            hit(index_reg, `LMRB_IDX_VOICE): rdMux = voice_reg;
            hit(index_reg, `LMRB_IDX_MIC): rdMux = mic_reg;
            hit(index_reg, `LMRB_IDX_SOURCE): rdMux = source_reg;
            hit(index_reg, `LMRB_IDX_FORMAT): rdMux = format_reg;
            hit(index_reg, `LMRB_IDX_MASTER): rdMux = master_reg;
            hit(index_reg, `LMRB_IDX_SYNTH): rdMux = synth_reg;
            hit(index_reg, `LMRB_IDX_CD): rdMux = cd_reg;
            hit(index_reg, `LMRB_IDX_LINE): rdMux = line_reg;
            default: rdMux = `LMRB_RD_NONE;
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ioRdData <= `LMRB_RD_NONE;
        end else if (dataRd) begin
            ioRdData <= rdMux;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // fields to the analog mixer; all straight from flip-flops

    assign voiceLeft = voice_reg[`LMRB_LEFT_HI:`LMRB_LEFT_LO];
    assign voiceRight = voice_reg[`LMRB_RIGHT_HI:`LMRB_RIGHT_LO];
    assign micLevel = mic_reg[`LMRB_MIC_HI:`LMRB_MIC_LO];
    assign recordSource = source_reg[`LMRB_SRC_HI:`LMRB_SRC_LO];
    assign stereo_output_select = format_reg[`LMRB_STEREO_BIT];
    assign masterLeft = master_reg[`LMRB_LEFT_HI:`LMRB_LEFT_LO];
    assign masterRight = master_reg[`LMRB_RIGHT_HI:`LMRB_RIGHT_LO];
    assign synthLeft = synth_reg[`LMRB_LEFT_HI:`LMRB_LEFT_LO];
    assign synthRight = synth_reg[`LMRB_RIGHT_HI:`LMRB_RIGHT_LO];
    assign cdLeft = cd_reg[`LMRB_LEFT_HI:`LMRB_LEFT_LO];
    assign cdRight = cd_reg[`LMRB_RIGHT_HI:`LMRB_RIGHT_LO];
    assign lineLeft = line_reg[`LMRB_LEFT_HI:`LMRB_LEFT_LO];
    assign lineRight = line_reg[`LMRB_RIGHT_HI:`LMRB_RIGHT_LO];

endmodule

// *** lmrb_mixer_regs_sva.sv ***
`timescale 1ns/1ps
// port-level checker for the mixer register bank
module lmrb_mixer_regs_sva (
    input wire clk,
    input wire rst_n,
    input wire ioWrStrobe,
    input wire ioRdStrobe,
    input wire [3:0] ioAddr,
    input wire [7:0] ioWrData,
    input wire [7:0] ioRdData,
    input wire [3:0] voiceLeft,
    input wire [3:0] voiceRight,
    input wire [2:0] micLevel,
    input wire [1:0] recordSource,
    input wire stereo_output_select,
    input wire [3:0] masterLeft,
    input wire [3:0] masterRight,
    input wire [3:0] synthLeft,
    input wire [3:0] synthRight,
    input wire [3:0] cdLeft,
    input wire [3:0] cdRight,
    input wire [3:0] lineLeft,
    input wire [3:0] lineRight
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    reg [7:0] idx_reg;
    wire dataWr = ioWrStrobe && ioAddr == 4'h5;
    ////////////////////////////////////////////////////////////////
    // shadow of the stored index, kept from port writes alone
    always @(posedge clk or negedge rst_n)
        if (!rst_n)
            idx_reg <= 8'h00;
        else if (ioWrStrobe && ioAddr == 4'h4)
            idx_reg <= ioWrData;
    ////////////////////////////////////////////////////////////////
    voice_wr_a: assert property (dataWr && idx_reg == 8'h04 |=>
        {voiceLeft, voiceRight} == $past(ioWrData)) else $error("voice not loaded");
    mic_wr_a: assert property (dataWr && idx_reg == 8'h0A |=>
        micLevel == $past(ioWrData[2:0])) else $error("mic not loaded");
    source_wr_a: assert property (dataWr && idx_reg == 8'h0C |=>
        recordSource == $past(ioWrData[2:1])) else $error("source not loaded");
    format_wr_a: assert property (dataWr && idx_reg == 8'h0E |=>
        stereo_output_select == $past(ioWrData[1])) else $error("format not loaded");
    master_wr_a: assert property (dataWr && idx_reg == 8'h22 |=>
        {masterLeft, masterRight} == $past(ioWrData)) else $error("master not loaded");
    soft_reset_a: assert property (dataWr && idx_reg == 8'h00 |=>
        {voiceLeft, voiceRight, masterLeft, masterRight, micLevel} == 19'h4CCC9)
        else $error("soft reset missed");
    master_rd_a: assert property (ioRdStrobe && ioAddr == 4'h5 && idx_reg == 8'h22 |=>
        ioRdData == $past({masterLeft, masterRight})) else $error("bad read data");
    reserved_wr_a: assert property (dataWr && idx_reg == 8'h24 |=>
        $stable({voiceLeft, voiceRight, masterLeft, masterRight})) else $error("reserved hit");
    synth_wr_a: assert property (dataWr && idx_reg == 8'h26 |=>
        {synthLeft, synthRight} == $past(ioWrData)) else $error("synth not loaded");
    cd_wr_a: assert property (dataWr && idx_reg == 8'h28 |=>
        {cdLeft, cdRight} == $past(ioWrData)) else $error("cd not loaded");
    line_wr_a: assert property (dataWr && idx_reg == 8'h2E |=>
        {lineLeft, lineRight} == $past(ioWrData)) else $error("line not loaded");
endmodule
bind lmrb_mixer_regs lmrb_mixer_regs_sva chk_i (.clk(clk), .rst_n(rst_n),
    .ioWrStrobe(ioWrStrobe), .ioRdStrobe(ioRdStrobe), .ioAddr(ioAddr), .ioWrData(ioWrData),
    .ioRdData(ioRdData), .voiceLeft(voiceLeft), .voiceRight(voiceRight), .micLevel(micLevel),
    .recordSource(recordSource), .stereo_output_select(stereo_output_select),
    .masterLeft(masterLeft), .masterRight(masterRight), .synthLeft(synthLeft),
    .synthRight(synthRight), .cdLeft(cdLeft), .cdRight(cdRight), .lineLeft(lineLeft),
    .lineRight(lineRight));
